// File: rtl/gd_control.sv
// Contract
// - Each gate follows its own lone input
// - Interlock bit selects both-off for both-high
// - Deadtime bit enables minimum gap insertion
// - Two-bit field picks drain deglitch time
// - Thermal and undervoltage recover by themselves
// - Register reset and drain trip latch fault
// - All inputs low long enough clears latch
// - Clear timer needs a fresh all-low transition
// - Writing all ones to clear register clears
// - Power-up starts with latched reset fault
// - Ready pin masks per ready configuration
// - Fault pin shows reset plus masked causes
// - Bus target at fixed address, seven-bit
// - Power bits select buck output voltage
// - Power bits disable or enable regulators
// - Standby bit requests low consumption mode
// - Protected writes need low key inverse high
// - Unlocked key forces all gates low
// - All ones to reset register restores defaults
// - Command registers read back as all ones
// - Status register reports lock, reset, faults
// - Lock protects the listed registers only
// - Wake during standby delay aborts request
// - Ready low from request until standby entered
`default_nettype none
module gd_control #(
	parameter int STBY_DELAY_CYC = gd_pkg::STBY_DELAY_CYC
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	// Gate inputs and analog flags
	input  wire gd_pkg::gd_gates_s i_gates,
	input  wire logic             i_wake,
	input  wire logic             i_thermal,
	input  wire logic             i_undervolt,
	input  wire logic             i_drain_trip,
	// Two-wire bus
	input  wire logic             i_scl,
	input  wire logic             i_sda,
	output logic                  o_sda_out,
	output logic                  o_sda_oe,
	// Gate drives
	output gd_pkg::gd_gates_s     o_gates,
	// Open-drain status pins
	output logic                  o_ready_out,
	output logic                  o_ready_oe,
	output logic                  o_fault_out,
	output logic                  o_fault_oe,
	// Power management controls
	output logic [1:0]            o_buck_voltage_sel,
	output logic                  o_buck_disable,
	output logic                  o_ldo_disable,
	output logic                  o_standby_reg_en,
	output logic                  o_low_power
);
	logic [15:0]       sync1_reg;
	logic [15:0]       sync2_reg;
	gd_pkg::gd_gates_s gin;
	logic              wake_q, therm_q, uv_q, drain_q, scl_q, sda_q;
	logic              scl_prev_reg, sda_prev_reg;
	logic              scl_rise, scl_fall, i2c_start, i2c_stop;
	gd_pkg::gd_i2c_e   state_reg;
	logic [2:0]        bit_reg;
	logic [7:0]        shift_reg, tx_reg, ptr_reg, rx_byte;
	logic              wr_stb_reg;
	logic [7:0]        wr_addr_reg, wr_data_reg;
	logic [7:0]        power_reg, logic_reg, ready_reg, fault_reg, stby_reg, lock_reg;
	logic              lock_ok, wr_prot, do_clear, do_reset;
	logic              reset_flag_reg, drain_flag_reg, latched, all_low, drain_hit;
	logic [7:0]        deg_reg;
	logic              seen_high_reg;
	logic [11:0]       clr_reg;
	logic              clr_done;
	logic [19:0]       stby_cnt_reg;
	logic              low_power_reg, drive_en;
	logic [7:0]        status;

	// Pin synchronisers, bus lines idle high
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sync1_reg <= 16'h0003;
			sync2_reg <= 16'h0003;
		end else begin
			sync1_reg <= {4'h0, i_gates, i_wake, i_thermal, i_undervolt, i_drain_trip, i_scl, i_sda};
			sync2_reg <= sync1_reg;
		end
	end
	assign gin     = sync2_reg[11:6];
	assign wake_q  = sync2_reg[5];
	assign therm_q = sync2_reg[4];
	assign uv_q    = sync2_reg[3];
	assign drain_q = sync2_reg[2];
	assign scl_q   = sync2_reg[1];
	assign sda_q   = sync2_reg[0];

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_q;
			sda_prev_reg <= sda_q;
		end
	end
	assign scl_rise  = scl_q & ~scl_prev_reg;
	assign scl_fall  = ~scl_q & scl_prev_reg;
	assign i2c_start = scl_q & scl_prev_reg & sda_prev_reg & ~sda_q;
	assign i2c_stop  = scl_q & scl_prev_reg & ~sda_prev_reg & sda_q;
	assign rx_byte   = {shift_reg[6:0], sda_q};

	// Read data
	assign status = {~lock_ok, 3'h0, reset_flag_reg, drain_flag_reg, therm_q, uv_q};
	function automatic logic [7:0] rd_data(input logic [7:0] a);
		unique case (a)
			gd_pkg::OFS_POWER:  rd_data = power_reg;
			gd_pkg::OFS_LOGIC:  rd_data = logic_reg;
			gd_pkg::OFS_READY:  rd_data = ready_reg;
			gd_pkg::OFS_FAULT:  rd_data = fault_reg;
			gd_pkg::OFS_CLEAR:  rd_data = gd_pkg::CMD_ALL;
			gd_pkg::OFS_STBY:   rd_data = stby_reg;
			gd_pkg::OFS_LOCK:   rd_data = lock_reg;
			gd_pkg::OFS_RESET:  rd_data = gd_pkg::CMD_ALL;
			gd_pkg::OFS_STATUS: rd_data = status;
			default:            rd_data = 8'h00;
		endcase
	endfunction

	// Bus target state machine
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg   <= gd_pkg::I2C_IDLE;
			bit_reg     <= 3'h0;
			shift_reg   <= 8'h00;
			tx_reg      <= 8'h00;
			ptr_reg     <= 8'h00;
			o_sda_oe    <= 1'b0;
			wr_stb_reg  <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
		end else begin
			wr_stb_reg <= 1'b0;
			if (i2c_stop || low_power_reg) begin
				state_reg <= gd_pkg::I2C_IDLE;
				o_sda_oe  <= 1'b0;
			end else if (i2c_start) begin
				state_reg <= gd_pkg::I2C_ADDR;
				bit_reg   <= 3'h0;
				o_sda_oe  <= 1'b0;
			end else if (scl_fall) begin
				unique case (state_reg)
					gd_pkg::I2C_AACK, gd_pkg::I2C_PACK, gd_pkg::I2C_WACK: o_sda_oe <= 1'b1;
					gd_pkg::I2C_RDAT: begin
						o_sda_oe <= ~tx_reg[7];
						tx_reg   <= {tx_reg[6:0], 1'b0};
					end
					default: o_sda_oe <= 1'b0;
				endcase
			end else if (scl_rise) begin
				shift_reg <= rx_byte;
				bit_reg   <= bit_reg + 3'h1;
				unique case (state_reg)
					gd_pkg::I2C_IDLE: bit_reg <= 3'h0;
					gd_pkg::I2C_ADDR: if (bit_reg == 3'h7) begin
						state_reg <= (rx_byte[7:1] == gd_pkg::TARGET_ADDR) ?
							gd_pkg::I2C_AACK : gd_pkg::I2C_IDLE;
					end
					gd_pkg::I2C_AACK: begin
						bit_reg <= 3'h0;
						if (shift_reg[0]) begin
							state_reg <= gd_pkg::I2C_RDAT;
							tx_reg    <= rd_data(ptr_reg);
							ptr_reg   <= ptr_reg + 8'h01;
						end else begin
							state_reg <= gd_pkg::I2C_PTR;
						end
					end
					gd_pkg::I2C_PTR: if (bit_reg == 3'h7) begin
						state_reg <= gd_pkg::I2C_PACK;
						ptr_reg   <= rx_byte;
					end
					gd_pkg::I2C_PACK, gd_pkg::I2C_WACK: begin
						bit_reg   <= 3'h0;
						state_reg <= gd_pkg::I2C_WDAT;
					end
					gd_pkg::I2C_WDAT: if (bit_reg == 3'h7) begin
						state_reg   <= gd_pkg::I2C_WACK;
						wr_stb_reg  <= 1'b1;
						wr_addr_reg <= ptr_reg;
						wr_data_reg <= rx_byte;
						ptr_reg     <= ptr_reg + 8'h01;
					end
					gd_pkg::I2C_RDAT: if (bit_reg == 3'h7) begin
						state_reg <= gd_pkg::I2C_RACK;
					end
					gd_pkg::I2C_RACK: begin
						bit_reg <= 3'h0;
						if (!sda_q) begin
							state_reg <= gd_pkg::I2C_RDAT;
							tx_reg    <= rd_data(ptr_reg);
							ptr_reg   <= ptr_reg + 8'h01;
						end else begin
							state_reg <= gd_pkg::I2C_IDLE;
						end
					end
				endcase
			end
		end
	end
	assign o_sda_out = 1'b0;

	// Write protection and commands
	assign lock_ok  = (lock_reg[3:0] == ~lock_reg[7:4]);
	assign wr_prot  = wr_stb_reg & lock_ok;
	assign do_clear = wr_stb_reg & (wr_addr_reg == gd_pkg::OFS_CLEAR) &
		(wr_data_reg == gd_pkg::CMD_ALL);
	assign do_reset = wr_prot & (wr_addr_reg == gd_pkg::OFS_RESET) &
		(wr_data_reg == gd_pkg::CMD_ALL);

	// Configuration registers
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			power_reg <= gd_pkg::RST_POWER;
			logic_reg <= gd_pkg::RST_LOGIC;
			ready_reg <= gd_pkg::RST_READY;
			fault_reg <= gd_pkg::RST_FAULT;
			lock_reg  <= gd_pkg::RST_LOCK;
		end else if (do_reset) begin
			power_reg <= gd_pkg::RST_POWER;
			logic_reg <= gd_pkg::RST_LOGIC;
			ready_reg <= gd_pkg::RST_READY;
			fault_reg <= gd_pkg::RST_FAULT;
			lock_reg  <= gd_pkg::RST_LOCK;
		end else if (wr_stb_reg) begin
			if (wr_prot && wr_addr_reg == gd_pkg::OFS_POWER) power_reg <= wr_data_reg;
			if (wr_prot && wr_addr_reg == gd_pkg::OFS_LOGIC) logic_reg <= wr_data_reg;
			if (wr_prot && wr_addr_reg == gd_pkg::OFS_FAULT) fault_reg <= wr_data_reg;
			if (wr_addr_reg == gd_pkg::OFS_READY) ready_reg <= wr_data_reg;
			if (wr_addr_reg == gd_pkg::OFS_LOCK) lock_reg <= wr_data_reg;
		end
	end
	assign o_buck_voltage_sel = power_reg[gd_pkg::B_VSEL +: 2];
	assign o_buck_disable     = power_reg[gd_pkg::B_BUCK_DIS];
	assign o_ldo_disable      = power_reg[gd_pkg::B_LDO_DIS];
	assign o_standby_reg_en   = power_reg[gd_pkg::B_STBY_REG];

	// Standby request, delay and wake abort
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			stby_reg      <= gd_pkg::RST_STBY;
			stby_cnt_reg  <= 20'h0_0000;
			low_power_reg <= 1'b0;
		end else if (do_reset) begin
			stby_reg      <= gd_pkg::RST_STBY;
			stby_cnt_reg  <= 20'h0_0000;
		end else if (wake_q) begin
			stby_reg      <= gd_pkg::RST_STBY;
			stby_cnt_reg  <= 20'h0_0000;
			low_power_reg <= 1'b0;
		end else if (wr_prot && wr_addr_reg == gd_pkg::OFS_STBY) begin
			stby_reg      <= wr_data_reg;
			stby_cnt_reg  <= 20'h0_0000;
		end else if (stby_reg[gd_pkg::B_STBY_REQ] && !low_power_reg) begin
			if (stby_cnt_reg == 20'(STBY_DELAY_CYC - 1)) begin
				low_power_reg <= 1'b1;
			end else begin
				stby_cnt_reg <= stby_cnt_reg + 20'h0_0001;
			end
		end
	end
	assign o_low_power = low_power_reg;

	// Drain monitor deglitch
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			deg_reg <= 8'h00;
		end else if (!drain_q || low_power_reg) begin
			deg_reg <= 8'h00;
		end else if (!drain_hit) begin
			deg_reg <= deg_reg + 8'h01;
		end
	end
	assign drain_hit = drain_q & ~low_power_reg &
		(deg_reg >= gd_pkg::deglitch_cycles(logic_reg[gd_pkg::B_DEG +: 2]) - 8'h01);

	// Latched faults, set wins over clear
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			reset_flag_reg <= 1'b1;
			drain_flag_reg <= 1'b0;
		end else begin
			reset_flag_reg <= do_reset | (reset_flag_reg & ~(do_clear | clr_done));
			drain_flag_reg <= drain_hit | (drain_flag_reg & ~(do_clear | clr_done));
		end
	end
	assign latched = reset_flag_reg | drain_flag_reg;
	assign all_low = ~|{gin.high, gin.low};

	// Input-low clearing timer
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			seen_high_reg <= 1'b0;
		end else if (do_reset || (drain_hit && !drain_flag_reg)) begin
			seen_high_reg <= ~all_low;
		end else if (!all_low) begin
			seen_high_reg <= 1'b1;
		end else if (clr_done) begin
			seen_high_reg <= 1'b0;
		end
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			clr_reg <= 12'h000;
		end else if (latched && all_low && seen_high_reg && !clr_done) begin
			clr_reg <= clr_reg + 12'h001;
		end else begin
			clr_reg <= 12'h000;
		end
	end
	assign clr_done = latched & all_low & seen_high_reg &
		(clr_reg == 12'(gd_pkg::FAULT_CLEAR_CYC - 1));

	// Gate drive permission
	assign drive_en = ~latched & ~lock_ok & ~therm_q & ~uv_q & ~low_power_reg;
	for (genvar g = 0; g < 3; g++) begin : g_bridge
		gd_half_bridge u_bridge (
			.i_clk         (i_clk),
			.i_resetn      (i_resetn),
			.i_high        (gin.high[g]),
			.i_low         (gin.low[g]),
			.i_enable      (drive_en),
			.i_interlock   (logic_reg[gd_pkg::B_INTERLOCK_ENABLE]),
			.i_deadtime_en (logic_reg[gd_pkg::B_MIN_DEADTIME_ENABLE]),
			.o_high        (o_gates.high[g]),
			.o_low         (o_gates.low[g])
		);
	end

	// Open-drain status pins
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ready_oe <= 1'b1;
			o_fault_oe <= 1'b1;
		end else begin
			o_ready_oe <= (ready_reg[gd_pkg::B_RDY_STBY] & stby_reg[gd_pkg::B_STBY_REQ] &
				~low_power_reg) |
				(ready_reg[gd_pkg::B_RDY_THERM] & therm_q) |
				(ready_reg[gd_pkg::B_RDY_UV] & uv_q);
			o_fault_oe <= reset_flag_reg |
				(fault_reg[gd_pkg::B_FLT_DRAIN] & drain_flag_reg) |
				(fault_reg[gd_pkg::B_FLT_THERM] & therm_q) |
				(fault_reg[gd_pkg::B_FLT_UV] & uv_q);
		end
	end
	assign o_ready_out = 1'b0;
	assign o_fault_out = 1'b0;
endmodule
`default_nettype wire

// File: rtl/gd_pkg.sv
`default_nettype none
package gd_pkg;
	// Clock and timing
	localparam int CLK_MHZ          = 25;
	localparam int DEADTIME_NS      = 250;
	localparam int DEAD_CYC         = ((DEADTIME_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
		(DEADTIME_NS * CLK_MHZ + 999) / 1000;
	localparam int FAULT_CLEAR_US   = 100;
	localparam int FAULT_CLEAR_CYC  = FAULT_CLEAR_US * CLK_MHZ;
	localparam int STBY_DELAY_US    = 1000;
	localparam int STBY_DELAY_CYC   = STBY_DELAY_US * CLK_MHZ;
	localparam int DEG_US_0         = 6;
	localparam int DEG_US_1         = 4;
	localparam int DEG_US_2         = 3;
	localparam int DEG_US_3         = 2;

	// Bus address and register offsets
	localparam logic [6:0] TARGET_ADDR = 7'h47;
	localparam logic [7:0] OFS_POWER  = 8'h01;
	localparam logic [7:0] OFS_LOGIC  = 8'h02;
	localparam logic [7:0] OFS_READY  = 8'h07;
	localparam logic [7:0] OFS_FAULT  = 8'h08;
	localparam logic [7:0] OFS_CLEAR  = 8'h09;
	localparam logic [7:0] OFS_STBY   = 8'h0A;
	localparam logic [7:0] OFS_LOCK   = 8'h0B;
	localparam logic [7:0] OFS_RESET  = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h80;
	localparam logic [7:0] CMD_ALL    = 8'hFF;

	// Reset values
	localparam logic [7:0] RST_POWER = 8'h00;
	localparam logic [7:0] RST_LOGIC = 8'h73;
	localparam logic [7:0] RST_READY = 8'h09;
	localparam logic [7:0] RST_FAULT = 8'h7F;
	localparam logic [7:0] RST_STBY  = 8'h00;
	localparam logic [7:0] RST_LOCK  = 8'h00;

	// Field positions
	localparam int B_INTERLOCK_ENABLE     = 0;
	localparam int B_MIN_DEADTIME_ENABLE     = 1;
	localparam int B_DEG       = 2;
	localparam int B_LDO_DIS   = 6;
	localparam int B_BUCK_DIS  = 5;
	localparam int B_STBY_REG  = 4;
	localparam int B_VSEL      = 0;
	localparam int B_RDY_STBY  = 3;
	localparam int B_RDY_THERM = 1;
	localparam int B_RDY_UV    = 0;
	localparam int B_FLT_DRAIN = 2;
	localparam int B_FLT_THERM = 1;
	localparam int B_FLT_UV    = 0;
	localparam int B_STBY_REQ  = 0;

	// Six gate lines of the three half-bridges
	typedef struct packed {
		logic [2:0] high;
		logic [2:0] low;
	} gd_gates_s;

	// Target protocol states
	typedef enum logic [8:0] {
		I2C_IDLE = 9'h001,
		I2C_ADDR = 9'h002,
		I2C_AACK = 9'h004,
		I2C_PTR  = 9'h008,
		I2C_PACK = 9'h010,
		I2C_WDAT = 9'h020,
		I2C_WACK = 9'h040,
		I2C_RDAT = 9'h080,
		I2C_RACK = 9'h100
	} gd_i2c_e;

	// Deglitch length in cycles for the two-bit select
	function automatic logic [7:0] deglitch_cycles(input logic [1:0] sel);
		unique case (sel)
			2'h0: deglitch_cycles = 8'(DEG_US_0 * CLK_MHZ);
			2'h1: deglitch_cycles = 8'(DEG_US_1 * CLK_MHZ);
			2'h2: deglitch_cycles = 8'(DEG_US_2 * CLK_MHZ);
			2'h3: deglitch_cycles = 8'(DEG_US_3 * CLK_MHZ);
		endcase
	endfunction
endpackage
`default_nettype wire

// File: rtl/gd_half_bridge.sv
`default_nettype none
module gd_half_bridge (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_resetn,
	// Inputs and configuration
	input  wire logic i_high,
	input  wire logic i_low,
	input  wire logic i_enable,
	input  wire logic i_interlock,
	input  wire logic i_deadtime_en,
	// Gate drives
	output logic      o_high,
	output logic      o_low
);
	logic [7:0] dead_reg;
	logic       want_h;
	logic       want_l;
	logic       block_h;
	logic       block_l;

	// Truth table with optional interlocking
	assign want_h  = i_enable & i_high & (~i_low | ~i_interlock);
	assign want_l  = i_enable & i_low & (~i_high | ~i_interlock);
	// No turn-on while the opposite side conducts or the gap runs
	assign block_h = i_deadtime_en & (o_low | (dead_reg != 8'h00));
	assign block_l = i_deadtime_en & (o_high | (dead_reg != 8'h00));

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_high <= 1'b0;
			o_low  <= 1'b0;
		end else begin
			o_high <= want_h & (o_high | ~block_h);
			o_low  <= want_l & (o_low | ~block_l);
		end
	end

	// Gap counter starts when a conducting gate turns off
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			dead_reg <= 8'h00;
		end else if ((o_high & ~want_h) | (o_low & ~want_l)) begin
			dead_reg <= 8'(gd_pkg::DEAD_CYC);
		end else if (dead_reg != 8'h00) begin
			dead_reg <= dead_reg - 8'h01;
		end
	end
endmodule
`default_nettype wire

// File: testbench/gd_checker.sv
`default_nettype none
module gd_checker (
	// Clock, reset and inputs
	input wire logic              i_clk,
	input wire logic              i_resetn,
	input wire gd_pkg::gd_gates_s i_gates,
	input wire logic              i_wake,
	input wire logic              i_thermal,
	input wire logic              i_scl,
	// Outputs
	input wire logic              o_sda_out,
	input wire logic              o_sda_oe,
	input wire gd_pkg::gd_gates_s o_gates,
	input wire logic              o_ready_out,
	input wire logic              o_fault_out,
	input wire logic              o_fault_oe,
	input wire logic              o_low_power
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	// High gate of bridge 0 turns off alone
	sequence s_high_off;
		$fell(o_gates.high[0]) && !o_gates.low[0];
	endsequence
	sequence s_low_quiet;
		!o_gates.low[0] [*6];
	endsequence

	AST_OPEN_DRAIN: assert property (!(o_sda_out || o_ready_out || o_fault_out))
		else $error("open-drain output driven high");
	AST_IDLE_OFF: assert property ((i_gates == '0) [*4] |-> o_gates == '0)
		else $error("gate on with all inputs low");
	AST_DEADTIME: assert property (s_high_off |=> s_low_quiet)
		else $error("low gate on inside deadtime");
	AST_THERMAL_OFF: assert property (i_thermal [*6] |-> o_gates == '0)
		else $error("gate on in thermal shutdown");
	AST_FAULT_OFF: assert property (o_fault_oe [*6] |-> o_gates == '0)
		else $error("gate on with fault shown");
	AST_RESET_FAULT: assert property ($rose(i_resetn) |-> o_fault_oe [*3])
		else $error("no fault after reset");
	AST_LOW_POWER_OFF: assert property (o_low_power [*4] |-> o_gates == '0)
		else $error("gate on in low power");
	AST_WAKE_EXIT: assert property (i_wake [*6] |-> !o_low_power)
		else $error("low power kept while wake high");
	AST_ACK_SCL_LOW: assert property ($rose(o_sda_oe) |-> !i_scl)
		else $error("data pulled while clock high");
endmodule

bind gd_control gd_checker u_checker (
	.i_clk(i_clk), .i_resetn(i_resetn), .i_gates(i_gates), .i_wake(i_wake),
	.i_thermal(i_thermal), .i_scl(i_scl), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
	.o_gates(o_gates), .o_ready_out(o_ready_out), .o_fault_out(o_fault_out),
	.o_fault_oe(o_fault_oe), .o_low_power(o_low_power)
);
`default_nettype wire

// File: testbench/gd_mcu_model.sv
`default_nettype none
module gd_mcu_model (
	// Clock and bus level
	input  wire logic i_clk,
	input  wire logic i_sda,
	// Pulls toward ground
	output logic      o_scl_low,
	output logic      o_sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	logic b;
	initial begin
		o_scl_low = 1'b0;
		o_sda_low = 1'b0;
	end
	task automatic hp();
		repeat (13) @(negedge i_clk);
	endtask
	// Start or repeated start
	task automatic start();
		o_sda_low = 1'b0;
		hp();
		o_scl_low = 1'b0;
		hp();
		o_sda_low = 1'b1;
		hp();
		o_scl_low = 1'b1;
	endtask
	task automatic stop();
		o_sda_low = 1'b1;
		hp();
		o_scl_low = 1'b0;
		hp();
		o_sda_low = 1'b0;
		hp();
	endtask
	task automatic bit_io(input logic d, output logic q);
		o_sda_low = !d;
		hp();
		o_scl_low = 1'b0;
		hp();
		q = i_sda;
		o_scl_low = 1'b1;
	endtask
	// Byte out MSB first, then release for the ninth bit
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(1'b1, b);
		ack = !b;
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] q;
		logic       a;
		start();
		xfer(8'h8e, q, a);
		xfer(p, q, a);
		xfer(d, q, a);
		stop();
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] q);
		logic a;
		start();
		xfer(8'h8e, q, a);
		xfer(p, q, a);
		start();
		xfer(8'h8f, q, a);
		xfer(8'hff, q, a);
		stop();
	endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	gd_pkg::gd_gates_s gin, gout;
	logic              clk = 1'b0;
	logic              rstn = 1'b0;
	logic              wake, therm, uv, trip;
	logic              scl_low, sda_low, sda_oe, rdy_oe, flt_oe, lp;
	logic              bdis, ldis, sreg, res_v, a;
	logic [1:0]        vsel;
	logic [7:0]        res, q;
	logic [7:0]        exp_q[$];
	string             res_nm;
	integer            seed = 63225;
	int                num_errors = 0;
	int                n_tests = 0;

	always #20 clk = !clk;

	gd_control #(.STBY_DELAY_CYC(200)) dut (
		.i_clk(clk), .i_resetn(rstn), .i_gates(gin), .i_wake(wake),
		.i_thermal(therm), .i_undervolt(uv), .i_drain_trip(trip),
		.i_scl(!scl_low), .i_sda(!(sda_low | sda_oe)), .o_sda_out(),
		.o_sda_oe(sda_oe), .o_gates(gout), .o_ready_out(), .o_ready_oe(rdy_oe),
		.o_fault_out(), .o_fault_oe(flt_oe), .o_buck_voltage_sel(vsel),
		.o_buck_disable(bdis), .o_ldo_disable(ldis), .o_standby_reg_en(sreg),
		.o_low_power(lp)
	);
	gd_mcu_model u_mcu (
		.i_clk(clk), .i_sda(!(sda_low | sda_oe)), .o_scl_low(scl_low), .o_sda_low(sda_low)
	);

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(string nm, logic [7:0] seen, logic [7:0] want);
		n_tests++;
		if (seen !== want) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, want, seen);
		end
	endtask
	// Driver side: note the expectation, then present the result
	task automatic note(string nm, logic [7:0] want, logic [7:0] seen);
		@(negedge clk);
		exp_q.push_back(want);
		res_nm = nm;
		res = seen;
		res_v = 1'b1;
		@(negedge clk);
		res_v = 1'b0;
	endtask
	task automatic rchk(string nm, logic [7:0] p, logic [7:0] want);
		u_mcu.rd(p, q);
		note(nm, want, q);
	endtask
	always @(posedge clk) begin
		if (res_v) begin
			check(res_nm, res, exp_q.pop_front());
		end
	end
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		give_verdict();
	end

	initial begin
		gin = '0;
		{wake, therm, uv, trip, res_v, res} = '0;
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		note("fault pin", 8'h01, {7'h00, flt_oe});
		note("ready pin", 8'h00, {7'h00, rdy_oe});
		rchk("ready cfg", 8'h07, 8'h09);
		rchk("fault cfg", 8'h08, 8'h7f);
		rchk("logic cfg", 8'h02, 8'h73);
		rchk("power cfg", 8'h01, 8'h00);
		rchk("status", 8'h80, 8'h88);
		rchk("clear reg", 8'h09, 8'hff);
		rchk("reset reg", 8'h0c, 8'hff);
		for (int i = 0; i < 2; i++) begin
			u_mcu.start();
			u_mcu.xfer(i ? 8'h90 : 8'h8e, q, a);
			u_mcu.stop();
			note("address ack", 8'(i == 0), {7'h00, a});
		end
		gin = 6'h24;
		repeat (8) @(negedge clk);
		note("latched gates", 8'h00, {2'b00, gout});
		u_mcu.wr(8'h09, 8'h7f);
		note("bad clear", 8'h01, {7'h00, flt_oe});
		u_mcu.wr(8'h09, 8'hff);
		repeat (4) @(negedge clk);
		note("clear", 8'h00, {7'h00, flt_oe});
		rchk("status clear", 8'h80, 8'h80);
		repeat (12) begin
			gin = 6'($random(seed));
			repeat (16) @(negedge clk);
			note("gates", {2'b00, gin.high & ~gin.low, gin.low & ~gin.high}, {2'b00, gout});
		end
		gin = 6'h3f;
		repeat (16) @(negedge clk);
		note("both high", 8'h00, {2'b00, gout});
		gin = 6'h07;
		u_mcu.wr(8'h07, 8'h0b);
		rchk("ready cfg locked", 8'h07, 8'h0b);
		therm = 1'b1;
		repeat (8) @(negedge clk);
		note("thermal pins", 8'h03, {6'h00, rdy_oe, flt_oe});
		note("thermal gates", 8'h00, {2'b00, gout});
		therm = 1'b0;
		repeat (16) @(negedge clk);
		note("thermal back", 8'h07, {2'b00, gout});
		uv = 1'b1;
		repeat (8) @(negedge clk);
		note("uv pins", 8'h03, {6'h00, rdy_oe, flt_oe});
		uv = 1'b0;
		gin = '0;
		trip = 1'b1;
		repeat (100) @(negedge clk);
		trip = 1'b0;
		repeat (8) @(negedge clk);
		note("short trip", 8'h00, {7'h00, flt_oe});
		trip = 1'b1;
		repeat (170) @(negedge clk);
		trip = 1'b0;
		note("trip", 8'h01, {7'h00, flt_oe});
		rchk("status trip", 8'h80, 8'h84);
		repeat (2600) @(negedge clk);
		note("stale low", 8'h01, {7'h00, flt_oe});
		gin = 6'h01;
		repeat (8) @(negedge clk);
		gin = '0;
		repeat (2600) @(negedge clk);
		note("input clear", 8'h00, {7'h00, flt_oe});
		u_mcu.wr(8'h02, 8'h72);
		rchk("locked write", 8'h02, 8'h73);
		u_mcu.wr(8'h0b, 8'h5a);
		gin = 6'h38;
		repeat (8) @(negedge clk);
		note("unlocked gates", 8'h00, {2'b00, gout});
		gin = 6'h3f;
		rchk("status open", 8'h80, 8'h00);
		u_mcu.wr(8'h02, 8'h72);
		u_mcu.wr(8'h01, 8'h73);
		note("power pins", 8'h73, {1'b0, ldis, bdis, sreg, 2'b00, vsel});
		u_mcu.wr(8'h0b, 8'h00);
		repeat (16) @(negedge clk);
		note("no interlock", 8'h3f, {2'b00, gout});
		gin = '0;
		u_mcu.wr(8'h0b, 8'h5a);
		u_mcu.wr(8'h0a, 8'h01);
		note("standby ready", 8'h01, {6'h00, lp, rdy_oe});
		repeat (200) @(negedge clk);
		note("low power", 8'h02, {6'h00, lp, rdy_oe});
		wake = 1'b1;
		repeat (8) @(negedge clk);
		wake = 1'b0;
		note("wake", 8'h00, {7'h00, lp});
		u_mcu.wr(8'h0a, 8'h01);
		wake = 1'b1;
		repeat (10) @(negedge clk);
		wake = 1'b0;
		repeat (250) @(negedge clk);
		note("abort", 8'h00, {7'h00, lp});
		rchk("standby bit", 8'h0a, 8'h00);
		u_mcu.wr(8'h0c, 8'h00);
		rchk("bad reset", 8'h02, 8'h72);
		u_mcu.wr(8'h0c, 8'hff);
		note("reset fault", 8'h01, {7'h00, flt_oe});
		rchk("logic default", 8'h02, 8'h73);
		rchk("status reset", 8'h80, 8'h88);
		@(negedge clk);
		give_verdict();
	end
endmodule
`default_nettype wire
